/* core/rxtx_cfg_map.vh */
`ifndef RXTX_CFG_MAP_VH
`define RXTX_CFG_MAP_VH
// Register addresses.
`define ADDR_DEMOD_CFG      6'h19
`define ADDR_RSVD_A         6'h1A
`define ADDR_RSVD_B         6'h1B
`define ADDR_TX_PARAMS      6'h1C
`define ADDR_RX_PARAMS      6'h1D
`define ADDR_RSVD_C         6'h1E
`define ADDR_UART_SPEED     6'h1F
// Reset values.
`define RST_DEMOD_CFG       8'h4D
`define RST_RSVD            8'h00
`define RST_TX_PARAMS       8'h62
`define RST_RX_PARAMS       8'h00
`define RST_UART_SPEED      8'hEB
// Reset values of the fields, split out of the register patterns above.
`define RST_TX_RSVD         6'h18
`define RST_RESP_WAIT       2'h2
`define RST_SPEED_HI        3'h7
`define RST_SPEED_LO        5'h0B
// Field positions.
`define CHAN_USE_HI         7
`define CHAN_USE_LO         6
`define FIXED_CHAN_BIT      5
`define PRESC_PARITY_BIT    4
`define RCV_TAU_HI          3
`define RCV_TAU_LO          2
`define BURST_TAU_HI        1
`define BURST_TAU_LO        0
`define RESP_WAIT_HI        1
`define RESP_WAIT_LO        0
`define PARITY_OFF_BIT      4
`define SPEED_HI_HI         7
`define SPEED_HI_LO         5
`define SPEED_LO_HI         4
`define SPEED_LO_LO         0
// Fixed offset added to the response wait field, in bit times.
`define RESP_WAIT_FIXED     4'h7
// Channel choice codes.
`define CHAN_I              1'b0
`define CHAN_Q              1'b1
`endif

/* core/channel_select.v */
`timescale 1ns/10ps
`include "rxtx_cfg_map.vh"
// Chooses the I or Q receive channel from the demodulator settings.
module channel_select (
    input  wire       clk,
    input  wire       srst,
    input  wire [1:0] channel_usage,
    input  wire       fixed_channel,
    input  wire       q_stronger,
    input  wire       in_comm,
    output reg        use_q_r
);
    reg  use_q_nxt;

    // Fixed mode overrides automatic choice; freeze holds the pick while communicating.
    always @* begin
        use_q_nxt = use_q_r;
        if (fixed_channel) begin
            use_q_nxt = channel_usage[0];
        end else if (channel_usage == 2'b00) begin
            use_q_nxt = q_stronger;
        end else if (channel_usage == 2'b01) begin
            if (!in_comm) begin
                use_q_nxt = q_stronger;
            end
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            use_q_r <= `CHAN_I;
        end else begin
            use_q_r <= use_q_nxt;
        end
    end
endmodule

/* core/timer_tick.v */
`timescale 1ns/10ps
// Divides the carrier-rate enable by 2*prescale+1 or 2*prescale+2.
module timer_tick (
    input  wire        clk,
    input  wire        srst,
    input  wire        carrier_en,
    input  wire [11:0] prescaler_value,
    input  wire        prescaler_parity,
    output reg         tick_r
);
    reg  [12:0] cnt_r;
    wire [12:0] last;

    assign last = {prescaler_value, 1'b0} + {12'h000, prescaler_parity};

    // The terminal count is compared live, so a new prescale takes effect within the current period.
    always @(posedge clk) begin
        if (srst) begin
            cnt_r  <= 13'h0000;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (carrier_en) begin
                if (cnt_r >= last) begin
                    cnt_r  <= 13'h0000;
                    tick_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 13'h0001;
                end
            end
        end
    end
endmodule

/* core/reader_rx_tx_config_regs.v */
`timescale 1ns/10ps
`include "rxtx_cfg_map.vh"
// Behaviour
// - The demodulator config register at 19h resets to 4Dh and is fully read/write.
// - Channel usage 00 picks the stronger channel, 01 also freezes it while communicating.
// - Automatic channel choice acts only while the fixed channel bit is 0.
// - With fixed channel set, usage bit 0 low forces I and high forces Q.
// - Parity bit 0 makes the timer tick at carrier over twice prescale plus one.
// - Parity bit 1 makes the timer tick at carrier over twice prescale plus two.
// - Receive time constant sets the PLL during reception, 00 freezes it.
// - Burst time constant sets the PLL during the burst phase.
// - Addresses 1Ah, 1Bh and 1Eh are reserved, read 00h and do nothing.
// - Transmit params at 1Ch reset to 62h with response wait in bits 1 to 0.
// - The additional response time is the response wait field plus 7 bits.
// - Receive params at 1Dh reset to 00h with only bit 4 writable.
// - Parity off stops parity generation on transmit and checking on receive.
// - With parity off, each received parity bit passes on as a data bit.
// - The UART speed register at 1Fh resets to EBh with 3-bit and 5-bit factors.
module reader_rx_tx_config_regs (
    input  wire        clk,
    input  wire        srst,
    input  wire [5:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata_r,
    output reg         reg_hit_r,
    input  wire        q_stronger,
    input  wire        in_comm,
    input  wire        receiving,
    input  wire        in_burst,
    input  wire        carrier_en,
    input  wire [11:0] prescaler_value,
    input  wire        rx_bit_valid,
    input  wire        rx_bit,
    input  wire        rx_is_parity,
    input  wire        rx_parity_ok,
    output reg         use_q_channel_r,
    output reg         timer_tick_r,
    output reg  [1:0]  pll_tau_r,
    output reg         pll_freeze_r,
    output reg  [3:0]  response_extra_r,
    output reg         tx_parity_gen_r,
    output reg         rx_data_valid_r,
    output reg         rx_data_r,
    output reg         rx_parity_err_r,
    output reg  [2:0]  speed_factor_hi_r,
    output reg  [4:0]  speed_factor_lo_r
);
    reg  [7:0] demod_cfg_r;
    reg  [1:0] response_wait_r;
    reg        parity_off_r;
    reg  [7:0] rdata_nxt;
    reg        hit_nxt;
    wire       use_q_w;
    wire       tick_w;
    wire       wr_demod;
    wire       wr_tx;
    wire       wr_rx;
    wire       wr_speed;

    // Register address compare, used by the write decodes only; the read mux decodes with a case.
    function match;
        input [5:0] addr;
        input [5:0] want;
        begin
            match = (addr == want);
        end
    endfunction

    assign wr_demod = reg_wr && match(reg_addr, `ADDR_DEMOD_CFG);
    assign wr_tx    = reg_wr && match(reg_addr, `ADDR_TX_PARAMS);
    assign wr_rx    = reg_wr && match(reg_addr, `ADDR_RX_PARAMS);
    assign wr_speed = reg_wr && match(reg_addr, `ADDR_UART_SPEED);

    // Register writes; reserved locations have no storage so writes vanish.
    always @(posedge clk) begin
        if (srst) begin
            demod_cfg_r       <= `RST_DEMOD_CFG;
            response_wait_r   <= `RST_RESP_WAIT;
            parity_off_r      <= 1'b0;
            speed_factor_hi_r <= `RST_SPEED_HI;
            speed_factor_lo_r <= `RST_SPEED_LO;
        end else begin
            if (wr_demod) begin
                demod_cfg_r <= reg_wdata;
            end
            if (wr_tx) begin
                response_wait_r <= reg_wdata[`RESP_WAIT_HI:`RESP_WAIT_LO];
            end
            if (wr_rx) begin
                parity_off_r <= reg_wdata[`PARITY_OFF_BIT];
            end
            if (wr_speed) begin
                speed_factor_hi_r <= reg_wdata[`SPEED_HI_HI:`SPEED_HI_LO];
                speed_factor_lo_r <= reg_wdata[`SPEED_LO_HI:`SPEED_LO_LO];
            end
        end
    end

    // Read mux; reserved bits of mixed registers return their reset pattern.
    always @* begin
        rdata_nxt = 8'h00;
        hit_nxt   = 1'b1;
        case (reg_addr)
            `ADDR_DEMOD_CFG: begin
                rdata_nxt = demod_cfg_r;
            end
            `ADDR_RSVD_A, `ADDR_RSVD_B, `ADDR_RSVD_C: begin
                rdata_nxt = `RST_RSVD;
            end
            `ADDR_TX_PARAMS: begin
                rdata_nxt = {`RST_TX_RSVD, response_wait_r};
            end
            `ADDR_RX_PARAMS: begin
                rdata_nxt = {3'h0, parity_off_r, 4'h0};
            end
            `ADDR_UART_SPEED: begin
                rdata_nxt = {speed_factor_hi_r, speed_factor_lo_r};
            end
            default: begin
                hit_nxt = 1'b0;
            end
        endcase
    end

    // Read data registers on a read strobe and holds until the next one.
    always @(posedge clk) begin
        if (srst) begin
            reg_rdata_r <= 8'h00;
            reg_hit_r   <= 1'b0;
        end else if (reg_rd) begin
            reg_rdata_r <= rdata_nxt;
            reg_hit_r   <= hit_nxt;
        end
    end

    channel_select u_chan (
        .clk           (clk),
        .srst          (srst),
        .channel_usage (demod_cfg_r[`CHAN_USE_HI:`CHAN_USE_LO]),
        .fixed_channel (demod_cfg_r[`FIXED_CHAN_BIT]),
        .q_stronger    (q_stronger),
        .in_comm       (in_comm),
        .use_q_r       (use_q_w)
    );

    timer_tick u_tick (
        .clk              (clk),
        .srst             (srst),
        .carrier_en       (carrier_en),
        .prescaler_value  (prescaler_value),
        .prescaler_parity (demod_cfg_r[`PRESC_PARITY_BIT]),
        .tick_r           (tick_w)
    );

    // Derived control outputs, all registered so the top drives from flops.
    always @(posedge clk) begin
        if (srst) begin
            use_q_channel_r  <= 1'b0;
            timer_tick_r     <= 1'b0;
            pll_tau_r        <= 2'h0;
            pll_freeze_r     <= 1'b0;
            response_extra_r <= 4'h0;
            tx_parity_gen_r  <= 1'b1;
        end else begin
            use_q_channel_r <= use_q_w;
            timer_tick_r    <= tick_w;
            if (receiving) begin
                pll_tau_r    <= demod_cfg_r[`RCV_TAU_HI:`RCV_TAU_LO];
                pll_freeze_r <= (demod_cfg_r[`RCV_TAU_HI:`RCV_TAU_LO] == 2'b00);
            end else if (in_burst) begin
                pll_tau_r    <= demod_cfg_r[`BURST_TAU_HI:`BURST_TAU_LO];
                pll_freeze_r <= 1'b0;
            end else begin
                pll_tau_r    <= demod_cfg_r[`BURST_TAU_HI:`BURST_TAU_LO];
                pll_freeze_r <= 1'b0;
            end
            response_extra_r <= {2'b00, response_wait_r} + `RESP_WAIT_FIXED;
            tx_parity_gen_r  <= ~parity_off_r;
        end
    end

    // Receive bit path; parity bits are consumed or forwarded by the switch.
    always @(posedge clk) begin
        if (srst) begin
            rx_data_valid_r <= 1'b0;
            rx_data_r       <= 1'b0;
            rx_parity_err_r <= 1'b0;
        end else begin
            rx_data_valid_r <= 1'b0;
            rx_parity_err_r <= 1'b0;
            if (rx_bit_valid) begin
                rx_data_r <= rx_bit;
                if (rx_is_parity && !parity_off_r) begin
                    rx_parity_err_r <= ~rx_parity_ok;
                end else begin
                    rx_data_valid_r <= 1'b1;
                end
            end
        end
    end

    // The speed factor registers above are the ports themselves, so no copy stage is needed.
endmodule

/* sim/rxtx_cfg_sva.sv */
`timescale 1ns/10ps
// Watches the host port and the parity path of the configuration bank.
module rxtx_cfg_sva (
    input wire       clk,
    input wire       srst,
    input wire [5:0] reg_addr,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata_r,
    input wire       reg_hit_r,
    input wire       rx_bit_valid,
    input wire       rx_is_parity,
    input wire       rx_data_valid_r,
    input wire       rx_parity_err_r,
    input wire       tx_parity_gen_r,
    input wire [3:0] response_extra_r,
    input wire [2:0] speed_factor_hi_r,
    input wire [4:0] speed_factor_lo_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    unmapped_rd_a: assert property (
        reg_rd && reg_addr < 6'h19 |=> reg_rdata_r == 8'h00 && !reg_hit_r) else $error("unmapped read");
    rsvd_read_a: assert property (
        reg_rd && (reg_addr == 6'h1A || reg_addr == 6'h1B || reg_addr == 6'h1E)
        |=> reg_rdata_r == 8'h00 && reg_hit_r) else $error("reserved read");
    rdata_hold_a: assert property (
        !reg_rd |=> $stable(reg_rdata_r)) else $error("read data moved");
    speed_write_a: assert property (
        reg_wr && reg_addr == 6'h1F |=> {speed_factor_hi_r, speed_factor_lo_r} == $past(reg_wdata))
        else $error("speed factors");
    resp_time_a: assert property (
        reg_wr && reg_addr == 6'h1C && reg_wdata[1:0] == 2'b11 |-> ##[1:2] response_extra_r == 4'hA)
        else $error("response time");
    tx_parity_a: assert property (
        reg_wr && reg_addr == 6'h1D && reg_wdata[4] |-> ##[1:2] !tx_parity_gen_r)
        else $error("parity generation");
    err_gated_a: assert property (
        rx_parity_err_r |-> tx_parity_gen_r) else $error("parity error while off");
    parity_data_a: assert property (
        rx_bit_valid && rx_is_parity && !tx_parity_gen_r |-> ##[1:2] rx_data_valid_r)
        else $error("parity bit dropped");
    // Main scenarios are reached.
    cover property (reg_rd && reg_addr == 6'h1F);
    cover property (rx_parity_err_r);
    cover property (reg_wr && reg_addr == 6'h1D && reg_wdata[4]);
endmodule
bind reader_rx_tx_config_regs rxtx_cfg_sva chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .reg_hit_r(reg_hit_r), .rx_bit_valid(rx_bit_valid), .rx_is_parity(rx_is_parity),
    .rx_data_valid_r(rx_data_valid_r), .rx_parity_err_r(rx_parity_err_r),
    .tx_parity_gen_r(tx_parity_gen_r), .response_extra_r(response_extra_r),
    .speed_factor_hi_r(speed_factor_hi_r), .speed_factor_lo_r(speed_factor_lo_r));

/* sim/reader_rx_tx_config_regs_tb.sv */
`timescale 1ns/10ps
module reader_rx_tx_config_regs_tb;
    logic        clk, srst, reg_wr, reg_rd, q_stronger, in_comm, receiving, in_burst;
    logic        carrier_en, rx_bit_valid, rx_bit, rx_is_parity, rx_parity_ok, sv, sd, se;
    logic [5:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [11:0] prescaler_value;
    wire  [7:0]  reg_rdata_r;
    wire  [3:0]  response_extra_r;
    wire  [2:0]  speed_factor_hi_r;
    wire  [4:0]  speed_factor_lo_r;
    wire  [1:0]  pll_tau_r;
    wire         reg_hit_r, use_q_channel_r, timer_tick_r, pll_freeze_r, tx_parity_gen_r;
    wire         rx_data_valid_r, rx_data_r, rx_parity_err_r;
    integer      num_errors = 0, n_tests = 0, cyc = 0, n;
    logic [5:0]  ta [9] = '{6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h00, 6'h3F};
    logic [7:0]  tv [9] = '{8'h4D, 8'h00, 8'h00, 8'h62, 8'h00, 8'h00, 8'hEB, 8'h00, 8'h00};
    logic [7:0]  wv [7] = '{8'hB2, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h55};
    logic [7:0]  wx [7] = '{8'hB2, 8'h00, 8'h00, 8'h63, 8'h10, 8'h00, 8'h55};

    reader_rx_tx_config_regs dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .reg_hit_r(reg_hit_r), .q_stronger(q_stronger), .in_comm(in_comm),
        .receiving(receiving), .in_burst(in_burst), .carrier_en(carrier_en),
        .prescaler_value(prescaler_value), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
        .rx_is_parity(rx_is_parity), .rx_parity_ok(rx_parity_ok),
        .use_q_channel_r(use_q_channel_r), .timer_tick_r(timer_tick_r), .pll_tau_r(pll_tau_r),
        .pll_freeze_r(pll_freeze_r), .response_extra_r(response_extra_r),
        .tx_parity_gen_r(tx_parity_gen_r), .rx_data_valid_r(rx_data_valid_r),
        .rx_data_r(rx_data_r), .rx_parity_err_r(rx_parity_err_r),
        .speed_factor_hi_r(speed_factor_hi_r), .speed_factor_lo_r(speed_factor_lo_r));

    // Free-running 125 MHz clock.
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    // A hung handshake must still end the run with a verdict.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors = num_errors + 1;
            give_verdict;
        end
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [11:0] g, input logic [11:0] e);
        n_tests = n_tests + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // Write strobe lasts one clock, driven off the sampling edge.
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk) reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clk) reg_wr = 0;
    endtask

    // Read data is registered, so it is looked at one edge after the strobe.
    task rdc(input logic [5:0] a, input logic [7:0] e, input logic h);
        @(negedge clk) reg_addr = a;
        reg_rd = 1;
        @(negedge clk) reg_rd = 0;
        chk(reg_rdata_r, e);
        chk(reg_hit_r, h);
    endtask

    // Sends one received bit and records what comes out within three cycles.
    task rxb(input logic b, input logic p, input logic ok);
        @(negedge clk) rx_bit_valid = 1;
        {rx_bit, rx_is_parity, rx_parity_ok} = {b, p, ok};
        @(negedge clk) rx_bit_valid = 0;
        {sv, sd, se} = 3'b000;
        repeat (3) begin
            if (rx_data_valid_r === 1'b1) {sv, sd} = {1'b1, rx_data_r};
            if (rx_parity_err_r === 1'b1) se = 1;
            @(negedge clk);
        end
    endtask

    // Counts clocks from one timer tick to the next.
    task tk;
        n = 0;
        do begin
            @(negedge clk);
            n = n + 1;
        end while (timer_tick_r !== 1'b1 && n < 40);
    endtask

    initial begin
        {srst, reg_wr, reg_rd, q_stronger, in_comm, receiving, in_burst} = 7'h01 << 6;
        {carrier_en, rx_bit_valid, rx_bit, rx_is_parity, rx_parity_ok} = 5'h00;
        {reg_addr, reg_wdata, prescaler_value} = 26'h0;
        repeat (2) @(negedge clk);
        srst = 0;
        @(negedge clk);
        chk({speed_factor_hi_r, speed_factor_lo_r, response_extra_r}, 12'hEB9);
        chk(tx_parity_gen_r, 1);
        for (int i = 0; i < 9; i++) rdc(ta[i], tv[i], i < 7);
        $display("reset values done");
        for (int i = 0; i < 7; i++) begin
            wr(ta[i], wv[i]);
            rdc(ta[i], wx[i], 1);
        end
        chk({speed_factor_hi_r, speed_factor_lo_r, response_extra_r}, 12'h55A);
        $display("write readback done");
        rxb(1, 1, 0);
        chk({sv, sd, se, tx_parity_gen_r}, 4'b1100);
        wr(6'h1D, 8'h00);
        rxb(0, 1, 0);
        chk({sv, se, tx_parity_gen_r}, 3'b011);
        $display("parity done");
        for (int i = 0; i < 4; i++) begin
            q_stronger = ~i[0];
            wr(6'h19, {i[1:0], 6'h20});
            repeat (3) @(negedge clk);
            chk(use_q_channel_r, i[0]);
        end
        for (int i = 0; i < 2; i++) begin
            wr(6'h19, 8'h00);
            q_stronger = i[0];
            repeat (3) @(negedge clk);
            chk(use_q_channel_r, i[0]);
        end
        wr(6'h19, 8'h40);
        q_stronger = 1;
        repeat (3) @(negedge clk);
        in_comm = 1;
        q_stronger = 0;
        repeat (3) @(negedge clk);
        chk(use_q_channel_r, 1);
        wr(6'h19, 8'h80);
        in_comm = 0;
        repeat (3) @(negedge clk);
        chk(use_q_channel_r, 1);
        $display("channel done");
        receiving = 1;
        wr(6'h19, 8'h02);
        repeat (3) @(negedge clk);
        chk(pll_freeze_r, 1);
        wr(6'h19, 8'h0E);
        repeat (3) @(negedge clk);
        chk({pll_tau_r, pll_freeze_r}, 3'b110);
        {receiving, in_burst} = 2'b01;
        repeat (3) @(negedge clk);
        chk(pll_tau_r, 2);
        $display("pll done");
        {carrier_en, prescaler_value} = 13'h1002;
        for (int i = 0; i < 2; i++) begin
            wr(6'h19, {3'h0, i[0], 4'h0});
            repeat (3) tk;
            chk(n, 5 + i);
        end
        $display("timer done");
        @(negedge clk) srst = 1;
        @(negedge clk) srst = 0;
        rdc(6'h1F, 8'hEB, 1);
        $display("second reset done");
        give_verdict;
    end
endmodule
